/* verilog/dsp_accumulator_datapath.sv */
// Purpose: 40-bit accumulator adder, saturation, flags, store and write-back
// Assumes: decoder issues at most one adder op and one store per cycle
// Notes: all state in one struct; outputs come straight from it
//
// Summary of operation
// - 40-bit adder on either accumulator, shifter-scaled input
// - add true data, subtract complement, optional zero
// - guard flag set when bits 39:32 differ
// - guard flag with its enable raises trap
// - clamp flags sticky, cleared only by software
// - saturation off: clamp records bit 39 overflow
// - any-flags are ORs of both accumulators
// - saturation chosen by enables and width select
// - 9.31 mode loads extreme value, sets clamp
// - 1.31 mode loads extreme value, no guard
// - catastrophic mode only flags, accumulator wraps
// - mac class writes other accumulator high word
// - write-back into pointer or at pointer, plus two
// - round logic combinational, truncates when not rounding
// - conventional round increments at low word 0x8000+
// - convergent tie increments only if bit 16
// - stores truncated or rounded, write-back always rounded
// - clamped store above range writes 0x7FFF
// - clamped store below range writes 0x8000
// - clamp off passes store value unchanged
// - shifter one cycle, signed count, up to 16
// - x bus word placement, dsp/mcu result widths
`timescale 1ns/1ps
module dsp_accumulator_datapath (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // decoder requests
  input wire dsp_pkg::dsp_cmd_t cmd,
  input wire dsp_pkg::shift_ctl_t shift_ctl,
  input wire dsp_pkg::store_req_t store_req,
  input wire logic [15:0] xbus_rdata,
  // core control bits
  input wire logic [1:0] accum_clamp_enables,
  input wire logic clamp_width_select,
  input wire logic store_clamp_enable,
  input wire logic round_mode_select,
  // trap control bits and flag clears
  input wire logic guard_trap_enable_a,
  input wire logic guard_trap_enable_b,
  input wire logic wrap_trap_enable,
  input wire logic clamp_clear_a,
  input wire logic clamp_clear_b,
  // pointer load from the register file
  input wire logic wb_ptr_load,
  input wire logic [15:0] wb_ptr_value,
  // accumulators and status
  output logic [39:0] accumulator_a,
  output logic [39:0] accumulator_b,
  output logic guard_overflow_a,
  output logic guard_overflow_b,
  output logic clamp_flag_a,
  output logic clamp_flag_b,
  output logic guard_overflow_any,
  output logic clamp_flag_any,
  output logic arith_trap,
  // x bus write and pointer
  output logic xbus_wvalid,
  output logic [15:0] xbus_waddr,
  output logic [15:0] xbus_wdata,
  output logic [15:0] writeback_pointer_reg,
  output logic [39:0] shift_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic guard_a;
    logic guard_b;
    logic clamp_a;
    logic clamp_b;
    logic trap;
    logic [15:0] wb_ptr;
    logic wvalid;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic [39:0] shift_out;
  } dp_state_t;

  dp_state_t st;              // registered state
  dp_state_t next_st;         // next state

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // guard bits not all equal
  function automatic logic guard_mixed(input logic [39:0] v);
    guard_mixed = !((&v[dsp_pkg::SIGN_BIT:dsp_pkg::GUARD_LO]) || !(|v[dsp_pkg::SIGN_BIT:dsp_pkg::GUARD_LO]));
  endfunction : guard_mixed

  // ops that pass data through the adder
  function automatic logic updates_acc(input dsp_pkg::op_kind_t k);
    updates_acc = (k != dsp_pkg::OP_NONE) && (k != dsp_pkg::OP_MOVSAC);
  endfunction : updates_acc

  // ops that ignore the old accumulator
  function automatic logic zero_side(input dsp_pkg::op_kind_t k);
    zero_side = (k == dsp_pkg::OP_LOAD) || (k == dsp_pkg::OP_CLR) || (k == dsp_pkg::OP_MPY) ||
                (k == dsp_pkg::OP_MULTIPLY_NEGATE_OP) || (k == dsp_pkg::OP_ED);
  endfunction : zero_side

  // mac class ops permitted to write back
  function automatic logic wb_allowed(input dsp_pkg::op_kind_t k);
    wb_allowed = (k == dsp_pkg::OP_MAC) || (k == dsp_pkg::OP_MSC) || (k == dsp_pkg::OP_CLR) ||
                 (k == dsp_pkg::OP_MOVSAC);
  endfunction : wb_allowed

  // ----------------------------------------------------------------
  // shifter and round/store
  // ----------------------------------------------------------------
  logic [39:0] shift_res;     // combinational shift result
  logic [39:0] store_src;     // accumulator feeding the round logic
  logic store_round_en;       // rounding requested
  logic [15:0] round_data;    // rounded, clamped word

  dsp_barrel_shifter u_shift (
    .acc_a(st.acc_a),
    .acc_b(st.acc_b),
    .xbus_data(xbus_rdata),
    .ctl(shift_ctl),
    .result(shift_res)
  );

  // store uses its own source; write-back the non-target accumulator
  assign store_src = store_req.valid ? (store_req.source_b ? st.acc_b : st.acc_a)
                                     : (cmd.target_b ? st.acc_a : st.acc_b);
  assign store_round_en = store_req.valid ? store_req.round : 1'b1;

  dsp_round_store u_round (
    .acc(store_src),
    .round_en(store_round_en),
    .conventional(round_mode_select),
    .clamp_en(store_clamp_enable),
    .data(round_data)
  );

  // ----------------------------------------------------------------
  // adder, saturation and flags
  // ----------------------------------------------------------------
  logic [39:0] side_a;        // accumulator side, may be zero
  logic [39:0] side_b;        // operand side, true or complemented
  logic [39:0] opnd;          // selected operand
  logic sub;                  // subtract
  logic [40:0] sum_full;      // adder with carry out
  logic [39:0] raw;           // unsaturated result
  logic ov39;                 // sign destroyed
  logic ov31;                 // outside 1.31 range
  logic neg_dir;              // true result is negative
  logic sat_en;               // saturation on for target
  logic mode31;               // 1.31 saturation active
  logic [39:0] new_acc;       // value written to target
  logic guard_new;            // next guard flag of target
  logic clamp_set;            // clamp event on target
  logic go;                   // adder op this cycle
  logic wb_go;                // write-back this cycle

  always_comb begin
    go = updates_acc(cmd.kind);
    sub = (cmd.kind == dsp_pkg::OP_SUB) || (cmd.kind == dsp_pkg::OP_MSC) ||
          (cmd.kind == dsp_pkg::OP_MULTIPLY_NEGATE_OP);
    opnd = (cmd.kind == dsp_pkg::OP_CLR) ? '0 : (cmd.use_shifter ? shift_res : cmd.operand);
    side_a = zero_side(cmd.kind) ? '0 : (cmd.target_b ? st.acc_b : st.acc_a);
    side_b = sub ? ~opnd : opnd;
    // carry-in low on add; high (carry one) on subtract
    sum_full = {1'b0, side_a} + {1'b0, side_b} + {40'h00_0000_0000, sub};
    raw = sum_full[39:0];
    ov39 = (side_a[39] == side_b[39]) && (raw[39] != side_a[39]);
    ov31 = ov39 || ((|raw[39:31]) && !(&raw[39:31]));
    neg_dir = ov39 ? side_a[39] : raw[39];
    sat_en = cmd.target_b ? accum_clamp_enables[0] : accum_clamp_enables[1];
    mode31 = sat_en && !clamp_width_select;
    new_acc = raw;
    clamp_set = 1'b0;
    if (mode31) begin
      clamp_set = ov31;
      if (ov31) begin
        new_acc = neg_dir ? dsp_pkg::MAX_NEG_32 : dsp_pkg::MAX_POS_32;
      end
    end else if (sat_en) begin
      clamp_set = ov39;
      if (ov39) begin
        new_acc = neg_dir ? dsp_pkg::MAX_NEG_40 : dsp_pkg::MAX_POS_40;
      end
    end else begin
      clamp_set = ov39;  // no saturation: wrap and flag only
    end
    // guard bits unused in 1.31 mode, so the flag stays clear
    guard_new = !mode31 && guard_mixed(new_acc);
    wb_go = cmd.wb_req && wb_allowed(cmd.kind) && !store_req.valid;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.trap = 1'b0;
    next_st.wvalid = 1'b0;
    next_st.shift_out = shift_res;
    // set wins over a software clear in the same cycle
    next_st.clamp_a = (st.clamp_a && !clamp_clear_a) || (go && !cmd.target_b && clamp_set);
    next_st.clamp_b = (st.clamp_b && !clamp_clear_b) || (go && cmd.target_b && clamp_set);
    if (go) begin
      // value and flags land in the same cycle
      if (cmd.target_b) begin
        next_st.acc_b = new_acc;
        next_st.guard_b = guard_new;
        next_st.trap = (guard_new && guard_trap_enable_b) || (!sat_en && ov39 && wrap_trap_enable);
      end else begin
        next_st.acc_a = new_acc;
        next_st.guard_a = guard_new;
        next_st.trap = (guard_new && guard_trap_enable_a) || (!sat_en && ov39 && wrap_trap_enable);
      end
    end
    if (wb_ptr_load) begin
      next_st.wb_ptr = wb_ptr_value;  // lowest priority
    end
    if (store_req.valid) begin
      next_st.wvalid = 1'b1;
      next_st.waddr = store_req.addr;
      next_st.wdata = round_data;
    end else if (wb_go && cmd.wb_indirect) begin
      next_st.wvalid = 1'b1;
      next_st.waddr = st.wb_ptr;
      next_st.wdata = round_data;
      next_st.wb_ptr = st.wb_ptr + dsp_pkg::WB_STEP;
    end else if (wb_go) begin
      next_st.wb_ptr = round_data;  // pointer takes the fraction
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign accumulator_a = st.acc_a;
  assign accumulator_b = st.acc_b;
  assign guard_overflow_a = st.guard_a;
  assign guard_overflow_b = st.guard_b;
  assign clamp_flag_a = st.clamp_a;
  assign clamp_flag_b = st.clamp_b;
  assign guard_overflow_any = st.guard_a | st.guard_b;
  assign clamp_flag_any = st.clamp_a | st.clamp_b;
  assign arith_trap = st.trap;
  assign xbus_wvalid = st.wvalid;
  assign xbus_waddr = st.waddr;
  assign xbus_wdata = st.wdata;
  assign writeback_pointer_reg = st.wb_ptr;
  assign shift_out = st.shift_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_guard_a;
    @(posedge clk_sys) disable iff (rst)
    (go && !cmd.target_b && !mode31) |=> (guard_overflow_a == guard_mixed(accumulator_a));
  endproperty
  a_guard_a: assert property (p_guard_a) else $error("guard flag a disagrees with accumulator");

  property p_guard_trap;
    @(posedge clk_sys) disable iff (rst)
    (go && !cmd.target_b && guard_new && guard_trap_enable_a) |=> arith_trap && guard_overflow_a;
  endproperty
  a_guard_trap: assert property (p_guard_trap) else $error("guard overflow did not trap");

  property p_clamp_sticky;
    @(posedge clk_sys) disable iff (rst)
    (clamp_flag_a && !clamp_clear_a) |=> clamp_flag_a;
  endproperty
  a_clamp_sticky: assert property (p_clamp_sticky) else $error("clamp flag a dropped by itself");

  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
    (go && !sat_en && ov39 && wrap_trap_enable) |=> arith_trap ##0 clamp_flag_any;
  endproperty
  a_wrap: assert property (p_wrap) else $error("unsaturated sign overflow not flagged");

  property p_any;
    @(posedge clk_sys) disable iff (rst)
    (guard_overflow_any == (guard_overflow_a || guard_overflow_b)) &&
    (clamp_flag_any == (clamp_flag_a || clamp_flag_b));
  endproperty
  a_any: assert property (p_any) else $error("summary flag is not the or");

  property p_sat39;
    @(posedge clk_sys) disable iff (rst)
    (go && !cmd.target_b && sat_en && clamp_width_select && ov39) |=>
      ((accumulator_a == dsp_pkg::MAX_POS_40) || (accumulator_a == dsp_pkg::MAX_NEG_40)) && clamp_flag_a;
  endproperty
  a_sat39: assert property (p_sat39) else $error("9.31 saturation value wrong");

  property p_sat31;
    @(posedge clk_sys) disable iff (rst)
    (go && !cmd.target_b && mode31 && ov31) |=>
      ((accumulator_a == dsp_pkg::MAX_POS_32) || (accumulator_a == dsp_pkg::MAX_NEG_32)) &&
      clamp_flag_a && !guard_overflow_a;
  endproperty
  a_sat31: assert property (p_sat31) else $error("1.31 saturation value wrong");

  property p_wraps;
    @(posedge clk_sys) disable iff (rst)
    (go && !cmd.target_b && !sat_en) |=> (accumulator_a == $past(raw));
  endproperty
  a_wraps: assert property (p_wraps) else $error("accumulator altered with saturation off");

  property p_no_wb;
    @(posedge clk_sys) disable iff (rst)
    (!store_req.valid && ((cmd.kind == dsp_pkg::OP_MPY) || (cmd.kind == dsp_pkg::OP_ED))) |=> !xbus_wvalid;
  endproperty
  a_no_wb: assert property (p_no_wb) else $error("excluded op wrote data space");

  property p_ptr_step;
    @(posedge clk_sys) disable iff (rst)
    (wb_go && cmd.wb_indirect) |=> xbus_wvalid &&
      (writeback_pointer_reg == xbus_waddr + dsp_pkg::WB_STEP);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced by one word");

  property p_store_sign;
    @(posedge clk_sys) disable iff (rst)
    (store_req.valid && store_clamp_enable && !store_src[39]) |=> !xbus_wdata[15];
  endproperty
  a_store_sign: assert property (p_store_sign) else $error("clamped positive store went negative");

  c_sat39: cover property (@(posedge clk_sys) disable iff (rst) go && sat_en && clamp_width_select && ov39);
  c_sat31: cover property (@(posedge clk_sys) disable iff (rst) go && mode31 && ov31);
  c_wb_ind: cover property (@(posedge clk_sys) disable iff (rst) wb_go && cmd.wb_indirect);
  c_store: cover property (@(posedge clk_sys) disable iff (rst) store_req.valid && store_req.round);

endmodule : dsp_accumulator_datapath

/* shared/dsp_pkg.sv */
// Purpose: shared constants and carrier types of the DSP accumulator datapath
// Assumes: 40-bit accumulators, 16-bit data words
// Notes: shared offsets and limits live here; some modules still use literal bit positions such as raw[39:31]
package dsp_pkg;

  // ----------------------------------------------------------------
  // widths and bit positions
  // ----------------------------------------------------------------
  localparam int ACC_W = 40;          // accumulator width
  localparam int WORD_W = 16;         // data space word
  localparam int SIGN_BIT = 39;       // accumulator sign
  localparam int GUARD_LO = 32;       // lowest guard bit
  localparam int FRAC_SIGN = 31;      // sign of a 1.31 value
  localparam int HI_LO = 16;          // lowest bit of the high word
  localparam int SHIFT_MAX = 16;      // largest shift distance
  localparam int SHIFT_CNT_W = 6;     // signed shift count width

  // ----------------------------------------------------------------
  // saturation and store limits
  // ----------------------------------------------------------------
  localparam logic [39:0] MAX_POS_40 = 40'h7F_FFFF_FFFF;  // 9.31 max
  localparam logic [39:0] MAX_NEG_40 = 40'h80_0000_0000;  // 9.31 min
  localparam logic [39:0] MAX_POS_32 = 40'h00_7FFF_FFFF;  // 1.31 max
  localparam logic [39:0] MAX_NEG_32 = 40'hFF_8000_0000;  // 1.31 min, sign extended
  localparam logic [15:0] STORE_MAX = 16'h7FFF;           // 1.15 max
  localparam logic [15:0] STORE_MIN = 16'h8000;           // 1.15 min
  localparam logic [15:0] HALF_LSW = 16'h8000;            // round tie point
  localparam logic [8:0] EXT_ONES = 9'h1FF;               // sign run of a fitting negative
  localparam logic [15:0] WB_STEP = 16'h0002;             // pointer step per word write

  // ----------------------------------------------------------------
  // operations from the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_LOAD, OP_CLR, OP_MAC, OP_MSC,
    OP_MOVSAC, OP_MPY, OP_MULTIPLY_NEGATE_OP, OP_ED, OP_EUCLID_DISTANCE_ACCUMULATE_OP
  } op_kind_t;

  typedef enum logic [1:0] {
    SRC_ACC_A, SRC_ACC_B, SRC_XBUS
  } shift_src_t;

  // adder command, one per cycle
  typedef struct packed {
    op_kind_t kind;             // operation
    logic target_b;             // 1 = accumulator_b is the target
    logic use_shifter;          // add/load take the shifter output
    logic wb_req;               // write back the other accumulator
    logic wb_indirect;          // 1 = to memory at the pointer, 0 = into the pointer
    logic [39:0] operand;       // product or extended data
  } dsp_cmd_t;

  // shifter control
  typedef struct packed {
    logic signed [5:0] count;   // >0 right, <0 left
    shift_src_t src;            // operand source
    logic logical;              // right shift fills zeros
    logic mcu;                  // 16-bit result
  } shift_ctl_t;

  // accumulator store request
  typedef struct packed {
    logic valid;                // store this cycle
    logic round;                // rounded store, else truncated
    logic source_b;             // 1 = accumulator_b
    logic [15:0] addr;          // data space address
  } store_req_t;

endpackage : dsp_pkg

/* verilog/dsp_barrel_shifter.sv */
// Purpose: 40-bit single-cycle barrel shifter
// Assumes: count saturates at the largest shift distance
// Notes: purely combinational; the datapath registers its result
`timescale 1ns/1ps
module dsp_barrel_shifter (
  // sources
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire logic [15:0] xbus_data,
  // control
  input wire dsp_pkg::shift_ctl_t ctl,
  // result
  output logic [39:0] result
);

  // ----------------------------------------------------------------
  // operand placement and shift
  // ----------------------------------------------------------------
  logic [39:0] operand;       // placed source
  logic [39:0] shifted;       // full width result
  logic [5:0] mag;            // shift distance
  logic right;                // direction

  always_comb begin
    right = (ctl.count > 0);
    mag = ctl.count[5] ? 6'(-ctl.count) : 6'(ctl.count);
    if (mag > 6'(dsp_pkg::SHIFT_MAX)) begin
      mag = 6'(dsp_pkg::SHIFT_MAX);  // limit of one cycle
    end
    case (ctl.src)
      dsp_pkg::SRC_ACC_A: operand = acc_a;
      dsp_pkg::SRC_ACC_B: operand = acc_b;
      dsp_pkg::SRC_XBUS: begin
        // right shifts see the word in the high half, left in the low
        if (right) begin
          operand = {{8{xbus_data[15] & ~ctl.logical}}, xbus_data, 16'h0000};
        end else begin
          operand = {24'h00_0000, xbus_data};
        end
      end
      default: operand = '0;
    endcase
    if (right && ctl.logical) begin
      shifted = operand >> mag;
    end else if (right) begin
      shifted = 40'($signed(operand) >>> mag);
    end else begin
      shifted = operand << mag;  // zero count falls through unchanged
    end
    // mcu shifts return one word, dsp shifts the whole width
    if (ctl.mcu && right) begin
      result = {24'h00_0000, shifted[31:16]};
    end else if (ctl.mcu) begin
      result = {24'h00_0000, shifted[15:0]};
    end else begin
      result = shifted;
    end
  end

endmodule : dsp_barrel_shifter

/* verilog/dsp_round_store.sv */
// Purpose: round logic and data space write saturation
// Assumes: the source accumulator is held stable for the cycle
// Notes: combinational; never alters the accumulator itself
`timescale 1ns/1ps
module dsp_round_store (
  // source
  input wire logic [39:0] acc,
  // control
  input wire logic round_en,
  input wire logic conventional,
  input wire logic clamp_en,
  // result
  output logic [15:0] data
);

  // ----------------------------------------------------------------
  // round then clamp
  // ----------------------------------------------------------------
  logic inc;                  // round increment
  logic [23:0] ext;           // guard plus high word after rounding
  logic pos_ov;               // above the 1.15 range
  logic neg_ov;               // below the 1.15 range

  always_comb begin
    // ties go up when conventional, to the even high word otherwise
    inc = round_en && acc[15] &&
          (conventional || (acc[15:0] != dsp_pkg::HALF_LSW) || acc[dsp_pkg::HI_LO]);
    ext = acc[39:16] + 24'(inc);  // truncation when inc is low
    // the sign comes from the source, not the rounded word
    pos_ov = !acc[dsp_pkg::SIGN_BIT] && (ext[23:15] != 9'h000);
    neg_ov = acc[dsp_pkg::SIGN_BIT] && (ext[23:15] != dsp_pkg::EXT_ONES);
    if (clamp_en && pos_ov) begin
      data = dsp_pkg::STORE_MAX;
    end else if (clamp_en && neg_ov) begin
      data = dsp_pkg::STORE_MIN;
    end else begin
      data = ext[15:0];
    end
  end

endmodule : dsp_round_store

/* verification/dsp_xbus_model.sv */
// Purpose: x bus model facing the datapath
// Assumes: one word per write
// Notes: read word changes every cycle, so a stale word never looks valid
`timescale 1ns/1ps
module dsp_xbus_model (
  // clock
  input wire logic clk_sys,
  // writes from the datapath
  input wire logic xbus_wvalid,
  input wire logic [15:0] xbus_wdata,
  // read word and last write seen
  output logic [15:0] xbus_rdata,
  output logic [15:0] last_wdata
);
  logic [15:0] pat = 16'hA5C3; // free-running pattern
  assign xbus_rdata = pat;
  // pattern steps each cycle; capture written words
  always @(posedge clk_sys) begin
    pat <= {pat[14:0], pat[15] ^ pat[13]};
    if (xbus_wvalid) last_wdata <= xbus_wdata;
  end
endmodule : dsp_xbus_model

/* verification/dsp_accumulator_datapath_test.sv */
// Purpose: self-checking bench of the accumulator datapath
// Assumes: one op or store at a time
// Notes: the x bus shifter source is never exercised by this bench
`timescale 1ns/1ps
module dsp_accumulator_datapath_test;
  // ----------------------------------------
  // signals, instances, tasks
  // ----------------------------------------
  logic clk_sys = 0, rst = 1, width = 0, st_cl = 0, conv = 0, gte = 0, wte = 0, clr = 0, pl = 0, sb;
  dsp_pkg::dsp_cmd_t cmd = '0;
  dsp_pkg::shift_ctl_t shift_ctl = '0;
  dsp_pkg::store_req_t store_req = '0;
  logic [15:0] rdata, waddr, wdata, wbp, lw, pv = 16'h0000;
  logic [1:0] sat_en = 0;
  logic [39:0] acc_a, acc_b, sh, v, w, s;
  logic ga, gb, ca, cb, gany, cany, trap, wv, ov, ec, eg, lg, m;
  int n_fail = 0, checked = 0, c;
  always #2.5 clk_sys = ~clk_sys;
  dsp_xbus_model i_bus (.clk_sys(clk_sys), .xbus_wvalid(wv), .xbus_wdata(wdata), .xbus_rdata(rdata),
    .last_wdata(lw));
  dsp_accumulator_datapath i_dut (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .shift_ctl(shift_ctl),
    .store_req(store_req), .xbus_rdata(rdata), .accum_clamp_enables(sat_en), .clamp_width_select(width),
    .store_clamp_enable(st_cl), .round_mode_select(conv), .guard_trap_enable_a(gte),
    .guard_trap_enable_b(gte), .wrap_trap_enable(wte), .clamp_clear_a(clr), .clamp_clear_b(clr),
    .wb_ptr_load(pl), .wb_ptr_value(pv), .accumulator_a(acc_a), .accumulator_b(acc_b),
    .guard_overflow_a(ga), .guard_overflow_b(gb), .clamp_flag_a(ca), .clamp_flag_b(cb),
    .guard_overflow_any(gany), .clamp_flag_any(cany), .arith_trap(trap), .xbus_wvalid(wv),
    .xbus_waddr(waddr), .xbus_wdata(wdata), .writeback_pointer_reg(wbp), .shift_out(sh));
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one adder op, then idle; f = target_b, use_shifter, wb_req, wb_indirect; clear and pointer load end at first edge
  task automatic op(input dsp_pkg::op_kind_t k, input logic [39:0] d, input logic [3:0] f = 4'h0);
    @(posedge clk_sys) begin cmd <= {k, f, d}; clr <= 0; pl <= 0; end
    @(posedge clk_sys) cmd <= '0;
    #1;
  endtask : op
  // rounded or truncated word, then optional 1.15 clamp
  function automatic logic [15:0] exp_st(input logic [39:0] a, input logic r, input logic c, input logic cl);
    logic [23:0] q;
    q = a[39:16] + 24'(r && (a[15:0] > 16'h8000 || (a[15:0] == 16'h8000 && (c || a[16]))));
    if (cl && !a[39] && q[23:15] != 9'h000) return 16'h7FFF;
    if (cl && a[39] && q[23:15] != 9'h1FF) return 16'h8000;
    return q[15:0];
  endfunction : exp_st
  task automatic complete_run();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // watchdog far beyond the few hundred cycles needed
  initial begin #20000; n_fail++; complete_run(); end
  initial begin
    void'($urandom(7));
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    ec = 0;
    repeat (20) begin
      @(posedge clk_sys) {gte, wte, sb} <= 3'($urandom);
      v = 40'({$urandom, $urandom});
      w = 40'({$urandom, $urandom});
      op(dsp_pkg::OP_LOAD, v);
      op(sb ? dsp_pkg::OP_SUB : dsp_pkg::OP_ADD, w);
      s = sb ? v - w : v + w;
      ov = v[39] == (w[39] ^ sb) && s[39] != v[39];
      eg = s[39:32] != 8'h00 && s[39:32] != 8'hFF;
      ec |= ov;
      chk(acc_a, s);
      chk(gany, eg);
      chk(cany, ec);
      chk(trap, (gte && eg) || (wte && ov));
    end
    @(posedge clk_sys) clr <= 1;
    op(dsp_pkg::OP_NONE, 40'h0);
    chk({ca, cb, cany}, 3'b000);
    $display("wrap test done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) begin sat_en <= 2'b10; width <= i != 2; clr <= 1; end
      v = i == 0 ? dsp_pkg::MAX_POS_40 : i == 1 ? dsp_pkg::MAX_NEG_40 : dsp_pkg::MAX_POS_32;
      op(dsp_pkg::OP_LOAD, v);
      op(i == 1 ? dsp_pkg::OP_SUB : dsp_pkg::OP_ADD, 40'h1);
      chk(acc_a, v);
      chk({ga, ca}, {i != 2, 1'b1});
    end
    $display("saturation test done");
    @(posedge clk_sys) sat_en <= 2'b00;
    for (int i = 0; i < 24; i++) begin
      v = 40'({$urandom, $urandom});
      if (i[0]) v[15:0] = 16'h8000;
      if (i[1]) v[39:31] = {9{v[30]}};
      op(dsp_pkg::OP_LOAD, v);
      @(posedge clk_sys) begin store_req <= '{1'b1, i[2], 1'b0, 16'(2 * i)}; {conv, st_cl} <= 2'($urandom); end
      @(posedge clk_sys) store_req <= '0;
      #1 chk({wv, waddr}, {1'b1, 16'(2 * i)});
      chk(wdata, exp_st(v, i[2], conv, st_cl));
      chk(acc_a, v);
    end
    $display("store test done");
    // pointer load, then write-back at and into the pointer from accumulator_a
    @(posedge clk_sys) begin pl <= 1; pv <= 16'($urandom); end
    v = 40'({$urandom, $urandom});
    w = 40'({$urandom, $urandom});
    s = 40'({$urandom, $urandom});
    op(dsp_pkg::OP_LOAD, v);
    op(dsp_pkg::OP_LOAD, w, 4'b1000);
    chk(acc_b, w);
    chk(gb, w[39:32] != 8'h00 && w[39:32] != 8'hFF);
    op(dsp_pkg::OP_MAC, s, 4'b1011);
    chk({wv, waddr, wdata}, {1'b1, pv, exp_st(v, 1'b1, conv, st_cl)});
    chk(wbp, 16'(pv + 16'h0002));
    chk(acc_b, w + s);
    op(dsp_pkg::OP_MSC, s, 4'b1010);
    chk({wv, wbp}, {1'b0, exp_st(v, 1'b1, conv, st_cl)});
    chk(acc_b, w);
    chk(lw, exp_st(v, 1'b1, conv, st_cl));
    // accumulator_b through the shifter into accumulator_a
    repeat (8) begin
      c = $urandom_range(32) - 16;
      {lg, m} = 2'($urandom);
      @(posedge clk_sys) shift_ctl <= {6'(c), dsp_pkg::SRC_ACC_B, lg, m};
      op(dsp_pkg::OP_LOAD, 40'h00_0000_0000, 4'b0100);
      v = c > 0 ? (lg ? w >> c : 40'($signed(w) >>> c)) : w << -c;
      v = m ? 40'(c > 0 ? v[31:16] : v[15:0]) : v;
      chk(acc_a, v);
      chk(sh, v);
    end
    $display("shift and write-back test done");
    complete_run();
  end
endmodule : dsp_accumulator_datapath_test
